// ===== logic/sleep_ctrl_pkg.sv
// constants and types shared by the sleep-mode and clock-gating controller
package sleep_ctrl_pkg;
  localparam int CLK_MHZ = 40;
  // register port
  localparam int       ADDR_W      = 8;
  localparam int       DATA_W      = 8;
  localparam bit [7:0] ADDR_SLEEP_MODE_CONTROL_REG   = 8'h00;
  localparam bit [7:0] ADDR_PRR    = 8'h01;
  localparam bit [7:0] ADDR_STATUS = 8'h02;
  localparam bit [7:0] SLEEP_MODE_CONTROL_REG_MASK   = 8'h0F;
  localparam bit [7:0] PRR_MASK    = 8'hB5;
  localparam bit [7:0] SLEEP_MODE_CONTROL_REG_RESET  = 8'h00;
  localparam bit [7:0] PRR_RESET   = 8'h00;
  // field positions
  localparam int SE_BIT      = 0;
  localparam int SM_LO       = 1;
  localparam int SM_HI       = 3;
  localparam int PR_ADC_BIT  = 0;
  localparam int PR_SPI_BIT  = 2;
  localparam int PR_TIM1_BIT = 4;
  localparam int PR_PSCR_BIT = 5;
  localparam int PR_PSC2_BIT = 7;
  // sleep mode codes
  localparam bit [2:0] MODE_IDLE    = 3'h0;
  localparam bit [2:0] MODE_ADCNR   = 3'h1;
  localparam bit [2:0] MODE_PWRDOWN = 3'h2;
  localparam bit [2:0] MODE_STANDBY = 3'h6;
  // clock source codes at or above this select a crystal or resonator
  localparam bit [3:0] XTAL_CODE_MIN = 4'h8;
  // timing
  localparam int WAKE_CNT_W      = 20;
  localparam int HALT_CYCLES     = 4;
  localparam int STANDBY_CYCLES  = 6;
  localparam int PD_WAKE_XTAL_US = 1000;
  localparam int PD_WAKE_RC_NS   = 2000;
  localparam int PD_WAKE_XTAL_CYC_DEF = PD_WAKE_XTAL_US * CLK_MHZ;
  localparam int PD_WAKE_RC_CYC  = (PD_WAKE_RC_NS * CLK_MHZ + 999) / 1000;

  typedef enum logic [1:0] {
    FSM_ACTIVE = 2'h0,
    FSM_SLEEP  = 2'h1,
    FSM_WAKE   = 2'h3,
    FSM_HALT   = 2'h2
  } fsm_t;

  typedef struct packed {
    logic main_osc;
    logic pll;
    logic adc;
    logic io;
    logic flash;
    logic cpu;
  } clk_en_t;

  typedef struct packed {
    logic psc2;
    logic pscr;
    logic tim1;
    logic spi;
    logic adc;
  } per_en_t;

  typedef struct packed {
    logic timer;
    logic power_stage_controller;
    logic spm_ee;
    logic adc_done;
    logic wdt;
    logic comparator;
    logic spi;
    logic other;
  } irq_req_t;

  typedef struct packed {
    logic external;
    logic watchdog;
    logic brownout;
  } rst_ev_t;
endpackage : sleep_ctrl_pkg

// ===== logic/sleep_ctrl.sv
// sleep-mode sequencer, clock-domain gating and per-peripheral clock stop
// How it works
// [RULE1] sleep entry needs sleep enable set then sleep instruction; mode field picks mode
// [RULE2] enabled interrupt wakes; core held four cycles after start-up, then handler
// [RULE3] register file and SRAM are never cleared by sleep or wake
// [RULE4] any reset during sleep wakes and restarts from the reset vector
// [RULE5] code 000 is Idle: only CPU and flash clocks stop
// [RULE6] Idle wakes on any enabled interrupt, external or internal
// [RULE7] entering Idle or ADC noise reduction with converter enabled starts a conversion
// [RULE8] code 001 is ADC noise reduction: I/O, CPU and flash clocks stop
// [RULE9] noise reduction wakes on conversion done, resets, timer, SPM/EEPROM, level lines
// [RULE10] code 010 is Power-down: all generated clocks and oscillator stop
// [RULE11] Power-down wakes on resets, power stage, level lines; never on edges
// [RULE12] outside source holds wake level long enough to be registered
// [RULE13] Power-down wake waits a start-up delay chosen by the clock source fuses
// [RULE14] code 110 with crystal is Standby: oscillator runs, wake in six cycles
// [RULE15] power-reduction bit stops a peripheral clock and blocks its registers
// [RULE16] clearing the bit restarts the clock with the frozen state intact
// [RULE17] software should disable a peripheral before stopping its clock
// [RULE18] peripheral gating matters in Active and Idle; deeper modes stop clocks anyway
// [RULE19] main source on in Idle, noise reduction, Standby; PLL, ADC in first two
// [RULE20] software sets sleep enable just before sleeping and clears it after waking
// [RULE21] codes 011, 100, 101, 111 are reserved
// [RULE22] sleep with enable clear or reserved code just continues, nothing gated
//
// The implementer's own choices: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
module sleep_ctrl #(
  parameter int PD_WAKE_XTAL_CYC = sleep_ctrl_pkg::PD_WAKE_XTAL_CYC_DEF
) (
  // clock and reset
  input  wire logic                            CLOCK,
  input  wire logic                            RST,
  // register port
  input  wire logic [sleep_ctrl_pkg::ADDR_W-1:0] ADDR,
  input  wire logic [sleep_ctrl_pkg::DATA_W-1:0] WDATA,
  input  wire logic                            WR,
  input  wire logic                            RD,
  output logic      [sleep_ctrl_pkg::DATA_W-1:0] RDATA,
  // processor core
  input  wire logic                            SLEEP_EXEC,
  output logic                                 CORE_HALT,
  output logic                                 RESUME_IRQ,
  output logic                                 RESUME_VECTOR,
  // wake sources
  input  wire sleep_ctrl_pkg::irq_req_t        IRQ_REQ,
  input  wire sleep_ctrl_pkg::rst_ev_t         RESET_EVENTS,
  input  wire logic [2:0]                      EXTERNAL_INTERRUPT_LINES,
  input  wire logic [2:0]                      EXT_LEVEL_MODE,
  input  wire logic [2:0]                      EXT_ENABLE,
  // configuration
  input  wire logic [3:0]                      CLOCK_SOURCE_FUSES,
  input  wire logic                            ADC_ENABLED,
  // clock gating and peripheral control
  output sleep_ctrl_pkg::clk_en_t              CLK_EN,
  output sleep_ctrl_pkg::per_en_t              PERIPH_CLK_EN,
  output sleep_ctrl_pkg::per_en_t              PERIPH_REG_EN,
  output logic                                 ADC_AUTO_START
);
  import sleep_ctrl_pkg::*;

  typedef struct packed {
    fsm_t                  fsm;
    logic [WAKE_CNT_W-1:0] cnt;
    logic                  vec_pending;
    logic [7:0]            sleep_mode_control_reg;
    logic [7:0]            power_reduction_reg;
    logic [3:0]            fuses;
    logic                  fuse_taken;
    logic [2:0]            s1;
    logic [2:0]            s2;
    logic [2:0]            s3;
    logic [2:0]            filt;
    logic [2:0]            prev;
    clk_en_t               clk;
    per_en_t               pen;
    per_en_t               preg;
    logic                  halt;
    logic                  resume_irq;
    logic                  resume_vec;
    logic                  adc_start;
    logic [7:0]            rdata;
  } st_t;

  st_t st_r;
  st_t st_nxt;

  logic [2:0] mode;
  logic       xtal;
  logic       mode_ok;
  logic [2:0] lvl;
  logic [2:0] edg;
  logic       rst_ev;
  logic       wake_src;

  assign mode = st_r.sleep_mode_control_reg[SM_HI:SM_LO];
  assign xtal = st_r.fuses >= XTAL_CODE_MIN;
  // reserved codes and Standby without crystal never sleep
  assign mode_ok = (mode == MODE_IDLE) || (mode == MODE_ADCNR) ||
                   (mode == MODE_PWRDOWN) || (mode == MODE_STANDBY && xtal); // [RULE21] [RULE14]
  // level lines are active low
  assign lvl = ~st_r.filt & EXT_LEVEL_MODE & EXT_ENABLE;
  assign edg = (st_r.filt ^ st_r.prev) & ~EXT_LEVEL_MODE & EXT_ENABLE;
  assign rst_ev = RESET_EVENTS.external | RESET_EVENTS.watchdog | RESET_EVENTS.brownout;

  always_comb begin
    unique case (mode)
      MODE_IDLE:  wake_src = (|IRQ_REQ) | (|lvl) | (|edg); // [RULE6]
      MODE_ADCNR: wake_src = IRQ_REQ.adc_done | IRQ_REQ.timer | IRQ_REQ.spm_ee |
                             IRQ_REQ.wdt | (|lvl); // [RULE9]
      // edge requests deliberately absent here
      default:    wake_src = IRQ_REQ.power_stage_controller | IRQ_REQ.wdt | (|lvl); // [RULE11]
    endcase
  end

  always_comb begin
    st_nxt = st_r;
    st_nxt.resume_irq = 1'b0;
    st_nxt.resume_vec = 1'b0;
    st_nxt.adc_start  = 1'b0;
    st_nxt.rdata      = 8'h00;
    // strap caught on the first edge after reset release
    if (!st_r.fuse_taken) begin
      st_nxt.fuses      = CLOCK_SOURCE_FUSES;
      st_nxt.fuse_taken = 1'b1;
    end
    // a wake level counts once s2 or s3 sees it; filt returns high only when s2 and s3 are both high
    st_nxt.s1   = EXTERNAL_INTERRUPT_LINES;
    st_nxt.s2   = st_r.s1;
    st_nxt.s3   = st_r.s2;
    st_nxt.filt = (st_r.s2 & st_r.s3) | (st_r.filt & ~(st_r.s2 ^ st_r.s3)); // [RULE12]
    st_nxt.prev = st_r.filt;
    if (WR && ADDR == ADDR_SLEEP_MODE_CONTROL_REG) begin
      st_nxt.sleep_mode_control_reg = WDATA & SLEEP_MODE_CONTROL_REG_MASK;
    end
    if (WR && ADDR == ADDR_PRR) begin
      st_nxt.power_reduction_reg = WDATA & PRR_MASK; // [RULE15] [RULE16]
    end
    if (RD) begin
      unique case (ADDR)
        ADDR_SLEEP_MODE_CONTROL_REG:   st_nxt.rdata = st_r.sleep_mode_control_reg;
        ADDR_PRR:    st_nxt.rdata = st_r.power_reduction_reg;
        ADDR_STATUS: st_nxt.rdata = {st_r.fuses, xtal, st_r.vec_pending, st_r.fsm};
        default:     st_nxt.rdata = 8'h00;
      endcase
    end
    unique case (st_r.fsm)
      FSM_ACTIVE: begin
        if (SLEEP_EXEC && st_r.sleep_mode_control_reg[SE_BIT] && mode_ok) begin // [RULE1] [RULE22]
          st_nxt.fsm = FSM_SLEEP;
          st_nxt.adc_start = ADC_ENABLED &&
                             (mode == MODE_IDLE || mode == MODE_ADCNR); // [RULE7]
        end
      end
      FSM_SLEEP: begin
        if (rst_ev || wake_src) begin
          st_nxt.vec_pending = rst_ev; // [RULE4]
          if (mode == MODE_IDLE || mode == MODE_ADCNR) begin
            st_nxt.fsm = FSM_HALT;
            st_nxt.cnt = WAKE_CNT_W'(HALT_CYCLES);
          end else begin
            st_nxt.fsm = FSM_WAKE;
            if (mode == MODE_STANDBY) begin
              st_nxt.cnt = WAKE_CNT_W'(STANDBY_CYCLES); // [RULE14]
            end else if (xtal) begin
              st_nxt.cnt = WAKE_CNT_W'(PD_WAKE_XTAL_CYC); // [RULE13]
            end else begin
              st_nxt.cnt = WAKE_CNT_W'(PD_WAKE_RC_CYC); // [RULE13]
            end
          end
        end
      end
      FSM_WAKE: begin
        if (st_r.cnt <= WAKE_CNT_W'(1)) begin
          st_nxt.fsm = FSM_HALT;
          st_nxt.cnt = WAKE_CNT_W'(HALT_CYCLES); // [RULE2]
        end else begin
          st_nxt.cnt = st_r.cnt - WAKE_CNT_W'(1);
        end
      end
      FSM_HALT: begin
        if (st_r.cnt <= WAKE_CNT_W'(1)) begin
          // core state untouched: resume or vector, never a memory clear
          st_nxt.fsm         = FSM_ACTIVE; // [RULE3]
          st_nxt.resume_vec  = st_r.vec_pending; // [RULE4]
          st_nxt.resume_irq  = ~st_r.vec_pending; // [RULE2]
          st_nxt.vec_pending = 1'b0;
        end else begin
          st_nxt.cnt = st_r.cnt - WAKE_CNT_W'(1);
        end
      end
    endcase
    // clock domains follow the next state so the outputs are registered
    st_nxt.clk = '1;
    if (st_nxt.fsm == FSM_WAKE) begin
      st_nxt.clk = '0;
      st_nxt.clk.main_osc = 1'b1;
    end else if (st_nxt.fsm == FSM_SLEEP) begin
      st_nxt.clk = '0;
      unique case (mode)
        MODE_IDLE: begin
          st_nxt.clk.io       = 1'b1; // [RULE5]
          st_nxt.clk.adc      = 1'b1; // [RULE19]
          st_nxt.clk.pll      = 1'b1;
          st_nxt.clk.main_osc = 1'b1;
        end
        MODE_ADCNR: begin
          st_nxt.clk.adc      = 1'b1; // [RULE8] [RULE19]
          st_nxt.clk.pll      = 1'b1;
          st_nxt.clk.main_osc = 1'b1;
        end
        MODE_STANDBY: st_nxt.clk.main_osc = 1'b1; // [RULE14] [RULE19]
        default:      st_nxt.clk.main_osc = 1'b0; // [RULE10]
      endcase
    end
    // peripheral gates ride on their domain clock
    st_nxt.pen.psc2 = ~st_nxt.power_reduction_reg[PR_PSC2_BIT] & st_nxt.clk.io; // [RULE18]
    st_nxt.pen.pscr = ~st_nxt.power_reduction_reg[PR_PSCR_BIT] & st_nxt.clk.io;
    st_nxt.pen.tim1 = ~st_nxt.power_reduction_reg[PR_TIM1_BIT] & st_nxt.clk.io;
    st_nxt.pen.spi  = ~st_nxt.power_reduction_reg[PR_SPI_BIT] & st_nxt.clk.io;
    st_nxt.pen.adc  = ~st_nxt.power_reduction_reg[PR_ADC_BIT] & st_nxt.clk.adc;
    st_nxt.preg = {~st_nxt.power_reduction_reg[PR_PSC2_BIT], ~st_nxt.power_reduction_reg[PR_PSCR_BIT],
                   ~st_nxt.power_reduction_reg[PR_TIM1_BIT], ~st_nxt.power_reduction_reg[PR_SPI_BIT],
                   ~st_nxt.power_reduction_reg[PR_ADC_BIT]}; // [RULE15]
    st_nxt.halt = st_nxt.fsm != FSM_ACTIVE;
  end

  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      st_r <= '{fsm: FSM_ACTIVE, sleep_mode_control_reg: SLEEP_MODE_CONTROL_REG_RESET, power_reduction_reg: PRR_RESET,
                clk: '1, pen: '1, preg: '1, s1: '1, s2: '1, s3: '1,
                filt: '1, prev: '1, default: '0};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign RDATA          = st_r.rdata;
  assign CORE_HALT      = st_r.halt;
  assign RESUME_IRQ     = st_r.resume_irq;
  assign RESUME_VECTOR  = st_r.resume_vec;
  assign CLK_EN         = st_r.clk;
  assign PERIPH_CLK_EN  = st_r.pen;
  assign PERIPH_REG_EN  = st_r.preg;
  assign ADC_AUTO_START = st_r.adc_start;

  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (RST);

  chk_halt_four: assert property ( // [RULE2]
    st_r.fsm == FSM_HALT && $past(st_r.fsm) != FSM_HALT
      |-> (st_r.fsm == FSM_HALT)[*4] ##1 st_r.fsm == FSM_ACTIVE)
    else $error("core not held exactly four cycles");
  chk_idle_clocks: assert property ( // [RULE5]
    st_r.fsm == FSM_SLEEP && mode == MODE_IDLE
      |-> !CLK_EN.cpu && !CLK_EN.flash && CLK_EN.io && CLK_EN.adc && CLK_EN.main_osc)
    else $error("idle clock set wrong");
  chk_adcnr_clocks: assert property ( // [RULE8]
    st_r.fsm == FSM_SLEEP && mode == MODE_ADCNR
      |-> !CLK_EN.io && !CLK_EN.cpu && CLK_EN.adc && CLK_EN.pll)
    else $error("noise reduction clock set wrong");
  chk_pd_clocks: assert property ( // [RULE10]
    st_r.fsm == FSM_SLEEP && mode == MODE_PWRDOWN |-> CLK_EN == '0)
    else $error("power-down leaves a clock on");
  chk_standby_six: assert property ( // [RULE14]
    st_r.fsm == FSM_SLEEP && mode == MODE_STANDBY && !rst_ev && wake_src
      |=> st_r.fsm == FSM_WAKE && CLK_EN.main_osc ##6 st_r.fsm == FSM_HALT)
    else $error("standby wake not six cycles");
  chk_reserved_stay: assert property ( // [RULE22]
    st_r.fsm == FSM_ACTIVE && SLEEP_EXEC && (!st_r.sleep_mode_control_reg[SE_BIT] || !mode_ok)
      |=> st_r.fsm == FSM_ACTIVE && CLK_EN == '1)
    else $error("sleep entered without enable or with bad code");
  chk_pd_no_edge: assert property ( // [RULE11]
    st_r.fsm == FSM_SLEEP && mode == MODE_PWRDOWN && !rst_ev && lvl == '0 &&
      !IRQ_REQ.power_stage_controller && !IRQ_REQ.wdt |=> st_r.fsm == FSM_SLEEP)
    else $error("power-down woke on a non-qualified source");
  // the start-up wait is counted down by the sequencer, so the vector path is checked in two steps
  chk_reset_vector: assert property ( // [RULE4]
    st_r.fsm == FSM_SLEEP && rst_ev |=> st_r.vec_pending && st_r.fsm != FSM_SLEEP)
    else $error("reset in sleep not noted for the vector");
  chk_vector_pulse: assert property ( // [RULE4]
    st_r.fsm == FSM_HALT && st_r.cnt <= WAKE_CNT_W'(1) && st_r.vec_pending
      |=> RESUME_VECTOR && !RESUME_IRQ && !CORE_HALT)
    else $error("noted reset did not restart at the vector");
  chk_wake_osc_only: assert property ( // [RULE13]
    st_r.fsm == FSM_WAKE |-> CLK_EN.main_osc && !CLK_EN.cpu && !CLK_EN.io && !CLK_EN.pll)
    else $error("start-up wait runs a clock other than the oscillator");
  chk_hold_clocks: assert property ( // [RULE2]
    st_r.fsm == FSM_HALT |-> CLK_EN == '1 && CORE_HALT)
    else $error("hold cycles without all clocks or without halt");
  chk_adc_autostart: assert property ( // [RULE7]
    $past(st_r.fsm) == FSM_ACTIVE && st_r.fsm == FSM_SLEEP && $past(ADC_ENABLED) &&
      (mode == MODE_IDLE || mode == MODE_ADCNR) |-> ADC_AUTO_START)
    else $error("conversion not started on sleep entry");
  chk_prr_gate: assert property ( // [RULE15]
    WR && ADDR == ADDR_PRR && WDATA[PR_ADC_BIT]
      |=> !PERIPH_CLK_EN.adc && !PERIPH_REG_EN.adc)
    else $error("adc clock not stopped by power-reduction bit");

  cov_idle_wake: cover property (
    st_r.fsm == FSM_SLEEP && mode == MODE_IDLE ##1 st_r.fsm == FSM_HALT);
  cov_pd_wake: cover property (
    st_r.fsm == FSM_WAKE && mode == MODE_PWRDOWN ##1 st_r.fsm == FSM_WAKE);
  cov_reset_wake: cover property (RESUME_VECTOR);
  cov_standby: cover property (st_r.fsm == FSM_SLEEP && mode == MODE_STANDBY);
endmodule : sleep_ctrl

// ===== dv/core_model.sv
// processor-core stand-in: issues the sleep instruction and follows halt and resume
`timescale 1ns/1ps
module core_model (
  // clock and reset
  input  wire logic CLOCK,
  input  wire logic RST,
  // controller side
  input  wire logic CORE_HALT,
  input  wire logic RESUME_IRQ,
  input  wire logic RESUME_VECTOR,
  output logic      SLEEP_EXEC
);
  logic [7:0] pc_r;

  initial SLEEP_EXEC = 1'b0;

  // one-cycle sleep instruction; the bench always writes the mode and sleep enable just before
  task automatic exec_sleep();
    SLEEP_EXEC <= 1'b1;
    @(posedge CLOCK);
    SLEEP_EXEC <= 1'b0;
  endtask : exec_sleep

  // fetch stalls while halted; a reset wake restarts at the vector
  always @(posedge CLOCK or posedge RST) begin
    if (RST) pc_r <= 8'h00;
    else if (RESUME_VECTOR) pc_r <= 8'h00;
    else if (!CORE_HALT) pc_r <= pc_r + 8'h01;
  end
endmodule : core_model

// ===== dv/test_sleep_ctrl.sv
// self-checking bench for the sleep-mode and clock-gating controller
`timescale 1ns/1ps
module test_sleep_ctrl;
  import sleep_ctrl_pkg::*;
  localparam int XC = 20;
  logic CLOCK = 1'b0, RST = 1'b1, WR = 1'b0, RD = 1'b0, adc_on = 1'b1, rd_seen = 1'b0;
  logic [7:0] ADDR = 8'h00, WDATA = 8'h00, RDATA, d, e;
  logic SLEEP_EXEC, CORE_HALT, RESUME_IRQ, RESUME_VECTOR, ADC_AUTO_START;
  irq_req_t IRQ_REQ = '0;
  rst_ev_t RESET_EVENTS = '0;
  logic [2:0] ext_lines = 3'h7, ext_level = 3'h7, ext_en = 3'h7;
  logic [3:0] fuses = 4'h8;
  clk_en_t CLK_EN;
  per_en_t PERIPH_CLK_EN, PERIPH_REG_EN;
  logic [7:0] rd_q[$];
  logic [1:0] rs_q[$];
  logic [2:0] rsv[4] = '{3'h3, 3'h4, 3'h5, 3'h7};
  logic [15:0] seed = 16'hBAB1;
  int err_count = 0, num_checks = 0, n;

  always #12.5 CLOCK = ~CLOCK;

  sleep_ctrl #(.PD_WAKE_XTAL_CYC(XC)) u_dut (
    .CLOCK(CLOCK), .RST(RST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
    .SLEEP_EXEC(SLEEP_EXEC), .CORE_HALT(CORE_HALT), .RESUME_IRQ(RESUME_IRQ),
    .RESUME_VECTOR(RESUME_VECTOR), .IRQ_REQ(IRQ_REQ), .RESET_EVENTS(RESET_EVENTS),
    .EXTERNAL_INTERRUPT_LINES(ext_lines), .EXT_LEVEL_MODE(ext_level), .EXT_ENABLE(ext_en),
    .CLOCK_SOURCE_FUSES(fuses), .ADC_ENABLED(adc_on), .CLK_EN(CLK_EN),
    .PERIPH_CLK_EN(PERIPH_CLK_EN), .PERIPH_REG_EN(PERIPH_REG_EN), .ADC_AUTO_START(ADC_AUTO_START));

  core_model u_core (.CLOCK(CLOCK), .RST(RST), .CORE_HALT(CORE_HALT), .RESUME_IRQ(RESUME_IRQ),
    .RESUME_VECTOR(RESUME_VECTOR), .SLEEP_EXEC(SLEEP_EXEC));

  task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  task automatic stop_test();
    err_count += rd_q.size() + rs_q.size();
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : stop_test

  function automatic logic [7:0] xs();
    seed = seed ^ (seed << 7);
    seed = seed ^ (seed >> 9);
    seed = seed ^ (seed << 8);
    return seed[7:0];
  endfunction : xs

  task automatic cyc(input int k);
    repeat (k) @(posedge CLOCK);
  endtask : cyc

  // each access ends one edge after the strobe drops, so strobes never re-assert in one step
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    ADDR <= a;
    WDATA <= v;
    WR <= 1'b1;
    @(posedge CLOCK);
    WR <= 1'b0;
    @(posedge CLOCK);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    ADDR <= a;
    RD <= 1'b1;
    rd_q.push_back(exp);
    @(posedge CLOCK);
    RD <= 1'b0;
    @(posedge CLOCK);
  endtask : rd

  task automatic do_reset(input logic [3:0] f);
    RST <= 1'b1;
    fuses <= f;
    cyc(12);
    RST <= 1'b0;
    cyc(3);
  endtask : do_reset

  task automatic sleep(input logic [2:0] m, input logic se, input logic [7:0] ck, input logic [7:0] pe,
                       input logic au, input logic hl);
    wr(ADDR_SLEEP_MODE_CONTROL_REG, {4'h0, m, se});
    u_core.exec_sleep();
    #1;
    check("halt", CORE_HALT, hl);
    check("clk_en", {2'h0, CLK_EN}, ck);
    check("per_clk", {3'h0, PERIPH_CLK_EN}, pe);
    check("auto_start", ADC_AUTO_START, au);
    @(posedge CLOCK);
  endtask : sleep

  // level sources are held until the resume pulse so the wake is registered
  task automatic wake(input logic [7:0] irq, input logic [2:0] rs, input logic [2:0] lines,
                      input int lo, input int hi, input logic [1:0] ex);
    IRQ_REQ <= irq_req_t'(irq);
    RESET_EVENTS <= rst_ev_t'(rs);
    ext_lines <= lines;
    rs_q.push_back(ex);
    for (n = 1; n <= 200; n++) begin
      @(posedge CLOCK);
      #1;
      if (RESUME_IRQ === 1'b1 || RESUME_VECTOR === 1'b1) break;
    end
    if (n > 200) begin
      check("wake_timeout", 8'h01, 8'h00);
      stop_test();
    end
    check("wake_cycles", 8'(n >= lo && n <= hi), 8'h01);
    check("halt_after", CORE_HALT, 8'h00);
    @(posedge CLOCK);
    IRQ_REQ <= '0;
    RESET_EVENTS <= '0;
    ext_lines <= 3'h7;
  endtask : wake

  task automatic still(input logic [7:0] irq, input logic [2:0] lines);
    IRQ_REQ <= irq_req_t'(irq);
    ext_lines <= lines;
    cyc(10);
    IRQ_REQ <= '0;
    ext_lines <= 3'h7;
    cyc(10);
    #1;
    check("still_asleep", CORE_HALT, 8'h01);
    @(posedge CLOCK);
  endtask : still

  // outcome watcher: takes the oldest note whenever a result shows
  always @(posedge CLOCK) begin
    if (rd_seen) begin
      if (rd_q.size() > 0) check("rdata", RDATA, rd_q.pop_front());
      else check("rdata_extra", 8'h01, 8'h00);
    end
    if (RESUME_IRQ === 1'b1 || RESUME_VECTOR === 1'b1) begin
      if (rs_q.size() > 0) check("resume", {6'h0, RESUME_IRQ, RESUME_VECTOR}, {6'h0, rs_q.pop_front()});
      else check("resume_extra", 8'h01, 8'h00);
    end
    rd_seen <= RD;
  end

  initial begin
    do_reset(4'h8);
    #1;
    check("rst_clk", {2'h0, CLK_EN}, 8'h3F);
    check("rst_per", {3'h0, PERIPH_REG_EN}, 8'h1F);
    @(posedge CLOCK);
    rd(ADDR_SLEEP_MODE_CONTROL_REG, 8'h00);
    rd(8'h07, 8'h00);
    // status: strap, crystal flag, no vector pending, sequencer idle
    rd(ADDR_STATUS, 8'h88);
    wr(ADDR_SLEEP_MODE_CONTROL_REG, 8'hFF);
    rd(ADDR_SLEEP_MODE_CONTROL_REG, 8'h0F);
    for (int i = 0; i < 4; i++) begin
      d = xs();
      e = {3'h0, ~d[7], ~d[5], ~d[4], ~d[2], ~d[0]};
      wr(ADDR_PRR, d);
      #1;
      check("prr_clk", {3'h0, PERIPH_CLK_EN}, e);
      check("prr_reg", {3'h0, PERIPH_REG_EN}, e);
      @(posedge CLOCK);
      rd(ADDR_PRR, d & PRR_MASK);
    end
    wr(ADDR_PRR, 8'h04);
    sleep(MODE_IDLE, 1'b1, 8'h3C, 8'h1D, 1'b1, 1'b1);
    wake(8'h01, 3'h0, 3'h7, 5, 5, 2'b10);
    sleep(MODE_ADCNR, 1'b1, 8'h38, 8'h01, 1'b1, 1'b1);
    still(8'h01, 3'h7);
    wake(8'h00, 3'h4, 3'h7, 5, 5, 2'b01);
    sleep(MODE_ADCNR, 1'b1, 8'h38, 8'h01, 1'b1, 1'b1);
    wake(8'h10, 3'h0, 3'h7, 5, 5, 2'b10);
    sleep(MODE_PWRDOWN, 1'b1, 8'h00, 8'h00, 1'b0, 1'b1);
    wake(8'h40, 3'h0, 3'h7, XC + 5, XC + 5, 2'b10);
    sleep(MODE_STANDBY, 1'b1, 8'h20, 8'h00, 1'b0, 1'b1);
    wake(8'h08, 3'h0, 3'h7, 11, 11, 2'b10);
    ext_level <= 3'h0;
    sleep(MODE_PWRDOWN, 1'b1, 8'h00, 8'h00, 1'b0, 1'b1);
    still(8'h00, 3'h6);
    ext_level <= 3'h7;
    wake(8'h00, 3'h0, 3'h6, XC + 5, XC + 10, 2'b10);
    foreach (rsv[i]) sleep(rsv[i], 1'b1, 8'h3F, 8'h1D, 1'b0, 1'b0);
    sleep(MODE_IDLE, 1'b0, 8'h3F, 8'h1D, 1'b0, 1'b0);
    // second reset in mid-run with an on-chip oscillator strap
    do_reset(4'h3);
    rd(ADDR_STATUS, 8'h30);
    sleep(MODE_STANDBY, 1'b1, 8'h3F, 8'h1F, 1'b0, 1'b0);
    sleep(MODE_PWRDOWN, 1'b1, 8'h00, 8'h00, 1'b0, 1'b1);
    wake(8'h40, 3'h0, 3'h7, 85, 85, 2'b10);
    adc_on <= 1'b0;
    ext_level <= 3'h0;
    sleep(MODE_IDLE, 1'b1, 8'h3C, 8'h1F, 1'b0, 1'b1);
    wake(8'h00, 3'h0, 3'h5, 5, 12, 2'b10);
    cyc(4);
    stop_test();
  end
endmodule : test_sleep_ctrl
